// ===== hw/lfosc_ctrl.sv
// LF oscillator control, legacy multiplier status, ext oscillator pin routing, AXI4-Lite slave
`timescale 1ns/1ps
// Summary of operation
// R1: Multiplier enable bit 7 always reads one, writes have no effect.
// R2: Multiplier initialize bit 6 and ready bit 5 always read one.
// R3: Multiplier input select bits 1:0 always read zero.
// R4: Multiplier bits 4:2 read zero; whole status register ignores writes.
// R5: LF oscillator enable bit 7 turns the oscillator on; resets to zero.
// R6: Divider code 00 divides by 8, 01 by 4, 10 by 2, 11 by 1.
// R7: Ready bit 6 is read only; one once frequency has settled.
// R8: Ready clears only on reset or a write changing the divider field.
// R9: Trim bits 5:2 go to the oscillator core; 0000 fastest, 1111 slowest.
// R10: Software changes trim only while the LF oscillator is disabled.
// R11: Falling LF edge captures in timer 2, rising edge captures in timer 3.
// R12: A capture copies current timer count bytes into that timer's reload bytes.
// R13: Crystal mode uses P0.2 as crystal pin a and P0.3 as pin b.
// R14: Capacitor, RC or CMOS mode uses only P0.3 as crystal pin b.
// R15: Software makes the crossbar skip every pin the oscillator occupies.
// R16: Software sets oscillator pins analog, or digital input in CMOS mode.
// R17: External oscillator output selectable as system clock or peripheral clock.
// R18: Multiplier status reports a working multiplier for software compatibility.
// R19: Ready rises a fixed number of oscillator cycles after enable or divider change.
// R20: Oscillator output passes a two-stage synchroniser before edge detection.
module lfosc_ctrl #(
    parameter int SETTLE_CYC = lfosc_pkg::LF_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address and data
    input  wire logic [lfosc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [lfosc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Oscillator core
    input  wire logic                  lf_osc_out,
    output logic                       lf_osc_enable,
    output logic [3:0]                 lf_osc_trim,
    output logic [1:0]                 lf_osc_divider,
    // Timer count bytes and reload load strobes
    input  wire logic [7:0]            t2_count_high,
    input  wire logic [7:0]            t2_count_low,
    input  wire logic [7:0]            t3_count_high,
    input  wire logic [7:0]            t3_count_low,
    output logic                       t2_capture,
    output logic                       t3_capture,
    output logic [15:0]                t2_reload,
    output logic [15:0]                t3_reload,
    // External oscillator pin use and clock routing
    output logic                       crystal_pin_a_use,
    output logic                       crystal_pin_b_use,
    output logic                       ext_sysclk_sel,
    output logic                       ext_periph_sel
);
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);

    typedef enum logic [1:0] {
        LFOSC_OFF_S   = 2'b01,
        LFOSC_WAIT_S  = 2'b10
    } lfosc_state_t;

    typedef struct packed {
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 have_aw;
        logic                 have_w;
        logic [7:0]           waddr;
        logic [7:0]           wdata;
        logic                 wstrb0;
        logic                 arready;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [7:0]           rdata;
        logic                 en;
        logic                 rdy;
        logic [3:0]           trim;
        logic [1:0]           div;
        logic [7:0]           ext_ctrl;
        logic [1:0]           cap_en;
        lfosc_state_t         st;
        logic [CNT_W-1:0]     cnt;
        logic                 sync1;
        logic                 sync2;
        logic                 sync3;
        logic                 t2_cap;
        logic                 t3_cap;
        logic [15:0]          t2_rl;
        logic [15:0]          t3_rl;
        logic                 pin_a;
        logic                 pin_b;
    } lfosc_regs_t;

    lfosc_regs_t r_reg;
    lfosc_regs_t r_next;

    logic       do_write;
    logic       osc_rise;
    logic       osc_fall;
    logic [2:0] ext_mode;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_next = r_reg;
        r_next.t2_cap = 1'b0;
        r_next.t3_cap = 1'b0;
        // Write channel: address and data accepted in either order
        if (s_axi_awvalid && r_reg.awready) begin
            r_next.awready = 1'b0;
            r_next.have_aw = 1'b1;
            r_next.waddr   = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && r_reg.wready) begin
            r_next.wready  = 1'b0;
            r_next.have_w  = 1'b1;
            r_next.wdata   = s_axi_wdata[7:0];
            r_next.wstrb0  = s_axi_wstrb[0];
        end
        do_write = r_reg.have_aw && r_reg.have_w && !r_reg.bvalid;
        if (do_write) begin
            r_next.bvalid  = 1'b1;
            r_next.have_aw = 1'b0;
            r_next.have_w  = 1'b0;
            r_next.bresp   = lfosc_pkg::AXI_OKAY;
            if (r_reg.wstrb0) begin
                case (r_reg.waddr)
                    lfosc_pkg::LF_CTRL_IDX: begin
                        r_next.en   = r_reg.wdata[lfosc_pkg::LF_EN_BIT]; // R5
                        r_next.trim = r_reg.wdata[lfosc_pkg::LF_TRIM_LSB +: 4]; // R9
                        r_next.div  = r_reg.wdata[lfosc_pkg::LF_DIV_LSB +: 2]; // R6
                    end
                    lfosc_pkg::EXT_CTRL_IDX: r_next.ext_ctrl = r_reg.wdata;
                    lfosc_pkg::CAP_CTRL_IDX: r_next.cap_en   = r_reg.wdata[1:0];
                    // Status register is read only: writes accepted and dropped
                    lfosc_pkg::MULT_STAT_IDX: r_next.bresp = lfosc_pkg::AXI_OKAY; // R4
                    lfosc_pkg::T2_CAPT_IDX, lfosc_pkg::T3_CAPT_IDX: r_next.bresp = lfosc_pkg::AXI_OKAY;
                    default: r_next.bresp = lfosc_pkg::AXI_SLVERR;
                endcase
            end
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid  = 1'b0;
            r_next.awready = 1'b1;
            r_next.wready  = 1'b1;
        end
        // Read channel
        if (s_axi_arvalid && r_reg.arready) begin
            r_next.arready = 1'b0;
            r_next.rvalid  = 1'b1;
            r_next.rresp   = lfosc_pkg::AXI_OKAY;
            case (s_axi_araddr[9:2])
                lfosc_pkg::LF_CTRL_IDX:   r_next.rdata = {r_reg.en, r_reg.rdy, r_reg.trim, r_reg.div}; // R7
                lfosc_pkg::MULT_STAT_IDX: r_next.rdata = lfosc_pkg::MULT_STAT_VALUE; // R1 R2 R3 R4 R18
                lfosc_pkg::EXT_CTRL_IDX:  r_next.rdata = r_reg.ext_ctrl;
                lfosc_pkg::CAP_CTRL_IDX:  r_next.rdata = {6'h00, r_reg.cap_en};
                lfosc_pkg::T2_CAPT_IDX:   r_next.rdata = r_reg.t2_rl[7:0];
                lfosc_pkg::T3_CAPT_IDX:   r_next.rdata = r_reg.t3_rl[7:0];
                default: begin
                    r_next.rdata = 8'h00;
                    r_next.rresp = lfosc_pkg::AXI_SLVERR;
                end
            endcase
        end
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid  = 1'b0;
            r_next.arready = 1'b1;
        end
        // Oscillator output sampled twice before anything looks at it
        r_next.sync1 = lf_osc_out; // R20
        r_next.sync2 = r_reg.sync1; // R20
        r_next.sync3 = r_reg.sync2;
        osc_rise = r_reg.sync2 && !r_reg.sync3;
        osc_fall = !r_reg.sync2 && r_reg.sync3;
        // Settling model counts oscillator rising edges
        case (r_reg.st)
            LFOSC_OFF_S: begin
                r_next.cnt = '0;
                if (r_reg.en) begin
                    r_next.st = LFOSC_WAIT_S;
                end
            end
            LFOSC_WAIT_S: begin
                if (!r_reg.en) begin
                    r_next.st  = LFOSC_OFF_S;
                end else if (osc_rise && !r_reg.rdy) begin
                    if (r_reg.cnt == CNT_W'(SETTLE_CYC - 1)) begin
                        r_next.rdy = 1'b1; // R19
                    end else begin
                        r_next.cnt = r_reg.cnt + 1'b1; // R19
                    end
                end
            end
            default: r_next.st = LFOSC_OFF_S;
        endcase
        // Divider change restarts settling; disable alone leaves ready set
        if (do_write && r_reg.wstrb0 && r_reg.waddr == lfosc_pkg::LF_CTRL_IDX
                && r_reg.wdata[lfosc_pkg::LF_DIV_LSB +: 2] != r_reg.div) begin
            r_next.rdy = 1'b0; // R8
            r_next.cnt = '0; // R19
        end
        // Captures only while oscillator runs and the timer's capture mode is on
        if (r_reg.en && r_reg.cap_en[0] && osc_fall) begin
            r_next.t2_cap = 1'b1; // R11
            r_next.t2_rl  = {t2_count_high, t2_count_low}; // R12
        end
        if (r_reg.en && r_reg.cap_en[1] && osc_rise) begin
            r_next.t3_cap = 1'b1; // R11
            r_next.t3_rl  = {t3_count_high, t3_count_low}; // R12
        end
        // Pin use from the external oscillator mode
        ext_mode = r_reg.ext_ctrl[lfosc_pkg::EXT_MODE_LSB +: 3];
        r_next.pin_a = (ext_mode == lfosc_pkg::EXT_XTAL) || (ext_mode == lfosc_pkg::EXT_XTAL_DIV2); // R13
        r_next.pin_b = (ext_mode != lfosc_pkg::EXT_OFF); // R13 R14
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg         <= '0;
            r_reg.awready <= 1'b1;
            r_reg.wready  <= 1'b1;
            r_reg.arready <= 1'b1;
            r_reg.trim    <= lfosc_pkg::LF_TRIM_RESET;
            r_reg.div     <= lfosc_pkg::LF_DIV_RESET;
            r_reg.st      <= LFOSC_OFF_S;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready     = r_reg.awready;
    assign s_axi_wready      = r_reg.wready;
    assign s_axi_bvalid      = r_reg.bvalid;
    assign s_axi_bresp       = r_reg.bresp;
    assign s_axi_arready     = r_reg.arready;
    assign s_axi_rvalid      = r_reg.rvalid;
    assign s_axi_rresp       = r_reg.rresp;
    assign s_axi_rdata       = {24'h000000, r_reg.rdata};
    assign lf_osc_enable     = r_reg.en; // R5
    assign lf_osc_trim       = r_reg.trim; // R9
    assign lf_osc_divider    = r_reg.div; // R6
    assign t2_capture        = r_reg.t2_cap;
    assign t3_capture        = r_reg.t3_cap;
    assign t2_reload         = r_reg.t2_rl;
    assign t3_reload         = r_reg.t3_rl;
    assign crystal_pin_a_use = r_reg.pin_a;
    assign crystal_pin_b_use = r_reg.pin_b;
    assign ext_sysclk_sel    = r_reg.ext_ctrl[lfosc_pkg::EXT_CLKSEL_BIT]; // R17
    assign ext_periph_sel    = r_reg.ext_ctrl[lfosc_pkg::EXT_PERSEL_BIT]; // R17

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence div_change_s;
        do_write && r_reg.wstrb0 && r_reg.waddr == lfosc_pkg::LF_CTRL_IDX
            && r_reg.wdata[1:0] != r_reg.div;
    endsequence

    mult_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == lfosc_pkg::MULT_STAT_IDX)
        |=> s_axi_rdata == 32'h000000E0) else $error("mult status read wrong"); // R1
    mult_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_axi_rvalid) && $past(s_axi_araddr[9:2]) == lfosc_pkg::MULT_STAT_IDX
        |-> s_axi_rdata[7:5] == 3'h7) else $error("mult high bits not set"); // R2
    mult_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_axi_rvalid) && $past(s_axi_araddr[9:2]) == lfosc_pkg::MULT_STAT_IDX
        |-> s_axi_rdata[4:0] == 5'h00) else $error("mult low bits not zero"); // R3
    enable_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && r_reg.wstrb0 && r_reg.waddr == lfosc_pkg::LF_CTRL_IDX)
        |=> lf_osc_enable == $past(r_reg.wdata[7]) && lf_osc_trim == $past(r_reg.wdata[5:2]))
        else $error("enable or trim not taken"); // R5
    div_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        div_change_s |=> !r_reg.rdy) else $error("ready not cleared on divider change"); // R8
    rdy_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        r_reg.rdy && !div_change_s |=> r_reg.rdy) else $error("ready dropped"); // R8
    rdy_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r_reg.rdy) |-> $past(r_reg.en) && $past(osc_rise)) else $error("ready without edge"); // R19
    t2_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r_reg.en && r_reg.cap_en[0] && osc_fall) |=> t2_capture
            && t2_reload == $past({t2_count_high, t2_count_low})) else $error("timer 2 capture"); // R12
    t3_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        t3_capture |-> $past(osc_rise)) else $error("timer 3 capture on wrong edge"); // R11
    pin_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
        crystal_pin_a_use |-> crystal_pin_b_use) else $error("pin a without pin b"); // R13
    pin_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 crystal_pin_b_use == ($past(ext_mode) != lfosc_pkg::EXT_OFF)) else $error("pin b use"); // R14
endmodule // lfosc_ctrl

// ===== hw/lfosc_pkg.sv
// Package: register map, field layout, reset values and codes of the LF oscillator control block
package lfosc_pkg;
    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0]  LF_CTRL_IDX      = 8'h86;
    localparam logic [7:0]  MULT_STAT_IDX    = 8'hB9;
    localparam logic [7:0]  EXT_CTRL_IDX     = 8'hC0;
    localparam logic [7:0]  CAP_CTRL_IDX     = 8'hC1;
    localparam logic [7:0]  T2_CAPT_IDX      = 8'hC2;
    localparam logic [7:0]  T3_CAPT_IDX      = 8'hC3;
    localparam int          ADDR_W           = 12;
    // Control register fields
    localparam int          LF_EN_BIT        = 7;
    localparam int          LF_RDY_BIT       = 6;
    localparam int          LF_TRIM_LSB      = 2;
    localparam int          LF_DIV_LSB       = 0;
    localparam logic [3:0]  LF_TRIM_RESET    = 4'h8;
    localparam logic [1:0]  LF_DIV_RESET     = 2'h0;
    // Divider codes
    localparam logic [1:0]  DIV_BY8          = 2'h0;
    localparam logic [1:0]  DIV_BY4          = 2'h1;
    localparam logic [1:0]  DIV_BY2          = 2'h2;
    localparam logic [1:0]  DIV_BY1          = 2'h3;
    // Fixed multiplier status: enable, init, ready set, rest zero
    localparam logic [7:0]  MULT_STAT_VALUE  = 8'hE0;
    // External oscillator modes, bits 6:4 of the ext control register
    localparam int          EXT_MODE_LSB     = 4;
    localparam int          EXT_CLKSEL_BIT   = 0;
    localparam int          EXT_PERSEL_BIT   = 1;
    localparam logic [2:0]  EXT_OFF          = 3'h0;
    localparam logic [2:0]  EXT_CMOS         = 3'h2;
    localparam logic [2:0]  EXT_CMOS_DIV2    = 3'h3;
    localparam logic [2:0]  EXT_RC           = 3'h4;
    localparam logic [2:0]  EXT_CAP          = 3'h5;
    localparam logic [2:0]  EXT_XTAL         = 3'h6;
    localparam logic [2:0]  EXT_XTAL_DIV2    = 3'h7;
    // Settling time of the LF oscillator in its own cycles
    localparam int          LF_SETTLE_CYC    = 16;
    localparam logic [1:0]  AXI_OKAY         = 2'h0;
    localparam logic [1:0]  AXI_SLVERR       = 2'h2;
endpackage

// ===== tb/lfosc_ctrl_tb.sv
// Self-checking testbench for the LF oscillator control block over AXI4-Lite
`timescale 1ns/1ps
module lfosc_ctrl_tb;
    localparam logic [11:0] A_LF  = {2'b00, lfosc_pkg::LF_CTRL_IDX, 2'b00};
    localparam logic [11:0] A_MS  = {2'b00, lfosc_pkg::MULT_STAT_IDX, 2'b00};
    localparam logic [11:0] A_EXT = {2'b00, lfosc_pkg::EXT_CTRL_IDX, 2'b00};
    localparam logic [11:0] A_CAP = {2'b00, lfosc_pkg::CAP_CTRL_IDX, 2'b00};
    localparam logic [1:0]  OK    = lfosc_pkg::AXI_OKAY;
    localparam logic [1:0]  ERR   = lfosc_pkg::AXI_SLVERR;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, osc, en, t2c, t3c, pa, pb, ssel, psel, p2, p3;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, trim;
    logic [1:0]  bresp, rresp, div;
    logic [15:0] c2, c3, rl2, rl3;
    logic [7:0]  hist;
    int          fail_count, checks_done, n2, n3;
    lfosc_ctrl #(.SETTLE_CYC(2)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .lf_osc_out(osc), .lf_osc_enable(en), .lf_osc_trim(trim), .lf_osc_divider(div),
        .t2_count_high(c2[15:8]), .t2_count_low(c2[7:0]), .t3_count_high(c3[15:8]), .t3_count_low(c3[7:0]),
        .t2_capture(t2c), .t3_capture(t3c), .t2_reload(rl2), .t3_reload(rl3), .crystal_pin_a_use(pa),
        .crystal_pin_b_use(pb), .ext_sysclk_sel(ssel), .ext_periph_sel(psel));
    lfosc_osc_model u_osc (.aclk(aclk), .aresetn(aresetn), .lf_osc_enable(en), .lf_osc_trim(trim),
        .lf_osc_divider(div), .lf_osc_out(osc));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 200);
        chk("bvalid", 32'h1, {31'h0, bvalid});
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        araddr <= a; arvalid <= 1'b1; n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 200);
        chk("rvalid", 32'h1, {31'h0, rvalid});
        d = rdata;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        rd(a, d);
        chk($sformatf("rdata %h", a), e, d);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
    endtask
    task automatic wait_ready(input logic [31:0] e);
        logic [31:0] v;
        int n;
        v = '0; n = 0;
        while (v[6] !== 1'b1 && n < 60) begin
            rd(A_LF, v);
            n++;
        end
        chk("ready set", e, v);
    endtask
    task automatic summarize;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Capture monitor: counts move after each check so a stale copy shows
    // ****************************************
    always @(posedge aclk) begin
        hist <= {hist[6:0], osc};
        p2 <= (t2c === 1'b1);
        p3 <= (t3c === 1'b1);
        if (p2) begin
            chk("t2 reload", {16'h0, c2}, {16'h0, rl2});
            c2 <= c2 + 16'h0101;
        end
        if (p3) begin
            chk("t3 reload", {16'h0, c3}, {16'h0, rl3});
            c3 <= c3 + 16'h0203;
        end
        if (t2c === 1'b1) begin
            n2++;
            chk("t2 after fall", 32'h0, {31'h0, hist[2]});
        end
        if (t3c === 1'b1) begin
            n3++;
            chk("t3 after rise", 32'h1, {31'h0, hist[2]});
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("ERROR watchdog expected finish seen timeout");
        summarize;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [2:0] md [0:6];
        int m;
        md = '{lfosc_pkg::EXT_OFF, lfosc_pkg::EXT_CMOS, lfosc_pkg::EXT_CMOS_DIV2, lfosc_pkg::EXT_RC,
               lfosc_pkg::EXT_CAP, lfosc_pkg::EXT_XTAL, lfosc_pkg::EXT_XTAL_DIV2};
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; bready = 1'b1; rready = 1'b1;
        awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; c2 = 16'h1234; c3 = 16'hA5C3;
        hist = '0; p2 = 1'b0; p3 = 1'b0; fail_count = 0; checks_done = 0; n2 = 0; n3 = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdchk(A_LF, {24'h0, 2'b00, lfosc_pkg::LF_TRIM_RESET, 2'b00}, OK);
        rdchk(A_MS, 32'h0000_00E0, OK);
        wr(A_MS, 32'h0000_001F, 4'hF, OK);
        rdchk(A_MS, 32'h0000_00E0, OK);
        // Trim only written while the oscillator is off
        for (int i = 0; i < 16; i++) begin
            wr(A_LF, (i << 2) | (i & 3), 4'hF, OK);
            chk("trim", i, {28'h0, trim});
            chk("divider", i & 3, {30'h0, div});
        end
        wr(A_LF, 32'h0000_0083, 4'h0, OK);
        chk("enable unstrobed", 32'h0, {31'h0, en});
        wr(A_LF, 32'h0000_0083, 4'hF, OK);
        chk("enable", 32'h1, {31'h0, en});
        rdchk(A_LF, 32'h0000_0083, OK);
        wait_ready(32'h0000_00C3);
        wr(A_LF, 32'h0000_0083, 4'hF, OK);
        rdchk(A_LF, 32'h0000_00C3, OK);
        wr(A_LF, 32'h0000_0003, 4'hF, OK);
        chk("disable", 32'h0, {31'h0, en});
        rdchk(A_LF, 32'h0000_0043, OK);
        wr(A_LF, 32'h0000_0081, 4'hF, OK);
        rdchk(A_LF, 32'h0000_0081, OK);
        wait_ready(32'h0000_00C1);
        wr(A_LF, 32'h0000_0083, 4'hF, OK);
        // Both capture modes on, then off
        wr(A_CAP, 32'h0000_0003, 4'hF, OK);
        repeat (200) @(posedge aclk);
        chk("t2 captured", 32'h1, {31'h0, n2 > 0});
        chk("t3 captured", 32'h1, {31'h0, n3 > 0});
        wr(A_CAP, 32'h0000_0000, 4'hF, OK);
        repeat (10) @(posedge aclk);
        m = n2 + n3;
        repeat (100) @(posedge aclk);
        chk("captures off", m, n2 + n3);
        rdchk(A_CAP, 32'h0, OK);
        // Last capture holds the count seen before the monitor advanced it
        rdchk({2'b00, lfosc_pkg::T2_CAPT_IDX, 2'b00}, {24'h0, c2[7:0] - 8'h01}, OK);
        rdchk({2'b00, lfosc_pkg::T3_CAPT_IDX, 2'b00}, {24'h0, c3[7:0] - 8'h03}, OK);
        // External oscillator modes and clock routing
        for (int i = 0; i < 7; i++) begin
            wr(A_EXT, {25'h0, md[i], 2'b00, i[1:0]}, 4'hF, OK);
            // Pin use is registered from the stored mode, one cycle after the write lands
            @(posedge aclk);
            chk("pin a", {31'h0, md[i] >= lfosc_pkg::EXT_XTAL}, {31'h0, pa});
            chk("pin b", {31'h0, md[i] != lfosc_pkg::EXT_OFF}, {31'h0, pb});
            chk("sysclk sel", {31'h0, i[0]}, {31'h0, ssel});
            chk("periph sel", {31'h0, i[1]}, {31'h0, psel});
        end
        rdchk(A_EXT, {25'h0, lfosc_pkg::EXT_XTAL_DIV2, 4'h2}, OK);
        wr(12'h100, 32'h0000_00FF, 4'hF, ERR);
        rdchk(12'h100, 32'h0, ERR);
        summarize;
    end
endmodule // lfosc_ctrl_tb

// ===== tb/lfosc_osc_model.sv
// Behavioural low-frequency oscillator core that drives the block's capture input
`timescale 1ns/1ps
module lfosc_osc_model #(
    parameter int BASE_HALF = 4
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Core controls
    input  wire logic       lf_osc_enable,
    input  wire logic [3:0] lf_osc_trim,
    input  wire logic [1:0] lf_osc_divider,
    // Divided oscillator output
    output logic            lf_osc_out
);
    int cnt;
    int half;
    // Higher divide code runs faster; larger trim bits 3:2 run slower, trim bits 1:0 are ignored
    assign half = (BASE_HALF << (3 - int'(lf_osc_divider))) + int'(lf_osc_trim[3:2]);
    // Output stands still low while disabled, so no stray edges reach the timers
    always @(posedge aclk) begin
        if (!aresetn || !lf_osc_enable) begin
            cnt <= 0;
            lf_osc_out <= 1'b0;
        end else if (cnt >= half - 1) begin
            cnt <= 0;
            lf_osc_out <= ~lf_osc_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // lfosc_osc_model
